// ==== design/esa_error_status_aggregator.sv ====
// error status aggregator: collects fault flags into one error byte
// assumes synchronous inputs, uart/i2c front ends and nv memory outside
// Functional notes
// - power-up self-test result recorded on the same edge that raises running
// - probes continuously checked against their ranges
// - each memory write started while no verify is pending read back and compared
// - fault pin low when byte nonzero
// - whole byte readable over uart or i2c
// - offset and range bits self-clear
// - bits 0, 2, 3, 4 and 6 sticky until uart overwrite, reserved bit 7 always low
// - bit 2 algorithm config error
// - bit 3 output generation error
// - bit 4 self-diagnostic error
// - bit 5 probe or input out of range
// - bit 6 memory operation error
// - simultaneous faults combine bitwise
`timescale 1ns/100ps
module esa_error_status_aggregator
  import esa_pkg::*;
#(
  parameter int unsigned PROBE_W = 12,
  parameter int unsigned NPROBE  = PROBES
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      selftest_done,
  input  wire logic                      selftest_fail,
  input  wire logic                      fatal_evt,
  input  wire logic                      offset_err,
  input  wire logic                      algo_evt,
  input  wire logic                      output_evt,
  input  wire logic                      diag_evt,
  input  wire logic                      input_fail,
  input  wire logic [NPROBE*PROBE_W-1:0] probe_val,
  input  wire logic [NPROBE*PROBE_W-1:0] probe_min,
  input  wire logic [NPROBE*PROBE_W-1:0] probe_max,
  input  wire logic                      nv_wr,
  input  wire logic [7:0]                nv_wr_data,
  input  wire logic                      nv_done,
  input  wire logic [7:0]                nv_rd_data,
  input  wire logic                      uart_wr,
  input  wire logic [7:0]                uart_wr_data,
  output logic      [7:0]                err_uart_q,
  output logic      [7:0]                err_i2c_q,
  output logic                           status_ok_q,
  output logic                           running_q,
  output logic                           nv_rd_q
);

  // refuse shapes that the probe slicing cannot serve
  if (NPROBE < 1) begin : g_bad_nprobe
    $error("esa: NPROBE must be at least one");
  end
  if (PROBE_W < 1) begin : g_bad_probe_w
    $error("esa: PROBE_W must be at least one");
  end

  // one reading outside its window
  function automatic logic out_of_range(input logic [PROBE_W-1:0] v,
                                        input logic [PROBE_W-1:0] lo,
                                        input logic [PROBE_W-1:0] hi);
    out_of_range = (v < lo) || (v > hi);
  endfunction : out_of_range

  // probe idx taken from a packed probe bus
  function automatic logic [PROBE_W-1:0] probe_at(input logic [NPROBE*PROBE_W-1:0] bus,
                                                  input int unsigned              idx);
    probe_at = bus[idx*PROBE_W +: PROBE_W];
  endfunction : probe_at

  // sticky base kept, new events and live levels added, reserved forced low
  function automatic logic [7:0] merge_byte(input logic [7:0] base,
                                            input logic [7:0] events,
                                            input logic [7:0] levels);
    merge_byte = ((base & ~SELF_CLEAR) | events | levels) & ~RSVD_MASK;
  endfunction : merge_byte

  esa_state_t     state_q;
  esa_wr_t        wr_q;
  logic [7:0]     wr_data_q;
  logic [7:0]     err_q;
  logic           test_end_d;
  logic           test_fail_d;
  logic           range_d;
  logic           mem_fail_d;
  logic [7:0]     set_d;
  logic [7:0]     level_d;
  logic [7:0]     base_d;
  logic [7:0]     err_d;

  // first selftest_done seen while still in the power-up test
  always_comb begin
    test_end_d  = (state_q == ESA_SELFTEST) && selftest_done;
    test_fail_d = test_end_d && selftest_fail;
  end

  // power-up test gates normal operation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ESA_SELFTEST;
    end else begin
      unique case (state_q)
        ESA_SELFTEST: begin
          if (selftest_done) state_q <= ESA_RUN;
        end
        ESA_RUN: state_q <= ESA_RUN;
        default: state_q <= ESA_SELFTEST;
      endcase
    end
  end

  // write verify: wait for completion, then one readback cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= ESA_WR_IDLE;
    end else begin
      unique case (wr_q)
        ESA_WR_IDLE: begin
          if (nv_wr) wr_q <= ESA_WR_BUSY;
        end
        ESA_WR_BUSY: begin
          if (nv_done) wr_q <= ESA_WR_READ;
        end
        ESA_WR_READ: wr_q <= ESA_WR_IDLE;
        default:     wr_q <= ESA_WR_IDLE;
      endcase
    end
  end

  // written data held from write start until the readback compare
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_data_q <= ERR_RESET;
    end else if (wr_q == ESA_WR_IDLE && nv_wr) begin
      wr_data_q <= nv_wr_data;
    end
  end

  // readback request stands in the same cycle as the compare
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_rd_q <= 1'b0;
    end else begin
      nv_rd_q <= (wr_q == ESA_WR_BUSY) && nv_done;
    end
  end

  // any probe outside its window, or a failed input, holds the range bit
  always_comb begin
    range_d = input_fail;
    for (int unsigned i = 0; i < NPROBE; i++) begin
      if (out_of_range(probe_at(probe_val, i), probe_at(probe_min, i),
                       probe_at(probe_max, i))) begin
        range_d = 1'b1;
      end
    end
  end

  always_comb begin
    mem_fail_d = (wr_q == ESA_WR_READ) && (nv_rd_data != wr_data_q);
  end

  // events that set sticky bits
  always_comb begin
    set_d             = ERR_RESET;
    set_d[BIT_FATAL]  = fatal_evt || test_fail_d;
    set_d[BIT_ALGO]   = algo_evt;
    set_d[BIT_OUTPUT] = output_evt;
    set_d[BIT_DIAG]   = diag_evt;
    set_d[BIT_MEMORY] = mem_fail_d;
  end

  // live conditions, gone as soon as the cause is gone
  always_comb begin
    level_d             = ERR_RESET;
    level_d[BIT_OFFSET] = offset_err;
    level_d[BIT_RANGE]  = range_d;
  end

  // host overwrite replaces the sticky base; same-cycle events still win
  always_comb begin
    if (uart_wr) begin
      base_d = uart_wr_data;
    end else begin
      base_d = err_q;
    end
  end

  always_comb begin
    err_d = merge_byte(base_d, set_d, level_d);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q <= ERR_RESET;
    end else begin
      err_q <= err_d;
    end
  end

  // host copies take the next byte so they track err_q exactly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_uart_q <= ERR_RESET;
    end else begin
      err_uart_q <= err_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_i2c_q <= ERR_RESET;
    end else begin
      err_i2c_q <= err_d;
    end
  end

  // fault pin takes the next byte too, so it is high only while err_q is all zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_ok_q <= 1'b1;
    end else begin
      status_ok_q <= (err_d == ERR_RESET);
    end
  end

  // running rises with the edge that records the test result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running_q <= 1'b0;
    end else begin
      running_q <= (state_q == ESA_RUN) || test_end_d;
    end
  end
endmodule : esa_error_status_aggregator

// ==== design/esa_pkg.sv ====
// constants for the error status aggregator
// assumes a single system clock and a power-on reset
package esa_pkg;
  localparam int unsigned BIT_FATAL  = 0;
  localparam int unsigned BIT_OFFSET = 1;
  localparam int unsigned BIT_ALGO   = 2;
  localparam int unsigned BIT_OUTPUT = 3;
  localparam int unsigned BIT_DIAG   = 4;
  localparam int unsigned BIT_RANGE  = 5;
  localparam int unsigned BIT_MEMORY = 6;
  localparam int unsigned BIT_RSVD   = 7;
  localparam logic [7:0]  ERR_RESET  = 8'h00;
  localparam logic [7:0]  SELF_CLEAR = 8'h22;
  localparam logic [7:0]  RSVD_MASK  = 8'h80;
  localparam int unsigned PROBES     = 4;

  typedef enum logic [1:0] {
    ESA_SELFTEST = 2'b00,
    ESA_RUN      = 2'b01
  } esa_state_t;

  typedef enum logic [1:0] {
    ESA_WR_IDLE = 2'b00,
    ESA_WR_BUSY = 2'b01,
    ESA_WR_READ = 2'b11
  } esa_wr_t;
endpackage : esa_pkg

// ==== verification/esa_chk_sva.sv ====
// checker: error byte relations, sees only the aggregator ports
`timescale 1ns/100ps
module esa_chk_sva (input wire logic clk, rst, selftest_done, offset_err, algo_evt,
  output_evt, diag_evt, input_fail, uart_wr, nv_done, status_ok_q, running_q, nv_rd_q,
  input wire logic [7:0] err_uart_q, err_i2c_q);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_verify; nv_done ##1 nv_rd_q; endsequence
  chk_boot_gate: assert property ($rose(running_q) |-> $past(selftest_done))
    else $error("run began early");
  chk_fault_pin: assert property (status_ok_q == (err_uart_q == 8'h00))
    else $error("fault pin");
  chk_copy_same: assert property (err_i2c_q == err_uart_q)
    else $error("copies differ");
  chk_rsvd_zero: assert property (!err_uart_q[7])
    else $error("reserved bit");
  chk_offset_follow: assert property (err_uart_q[1] == $past(offset_err))
    else $error("offset bit");
  chk_range_force: assert property (input_fail |=> err_uart_q[5])
    else $error("range bit");
  chk_algo_set: assert property (algo_evt |=> err_uart_q[2])
    else $error("algo bit");
  chk_output_set: assert property (output_evt |=> err_uart_q[3])
    else $error("output bit");
  chk_diag_sticky: assert property (err_uart_q[4] && !uart_wr |=> err_uart_q[4])
    else $error("diag bit lost");
  chk_nv_verify: assert property (nv_done |-> s_verify)
    else $error("no readback");
endmodule : esa_chk_sva
bind esa_error_status_aggregator esa_chk_sva u_chk (.clk(clk), .rst(rst),
  .selftest_done(selftest_done), .offset_err(offset_err), .algo_evt(algo_evt),
  .output_evt(output_evt), .diag_evt(diag_evt), .input_fail(input_fail), .uart_wr(uart_wr),
  .nv_done(nv_done), .status_ok_q(status_ok_q), .running_q(running_q), .nv_rd_q(nv_rd_q),
  .err_uart_q(err_uart_q), .err_i2c_q(err_i2c_q));

// ==== verification/esa_nv_model.sv ====
// memory model: keeps a written byte, reports completion, returns it on readback
`timescale 1ns/100ps
module esa_nv_model (input wire logic clk, nv_wr, nv_rd_q, corrupt,
  input wire logic [7:0] nv_wr_data, output logic nv_done = 1'b0,
  output logic [7:0] nv_rd_data);
  logic [7:0] mem_q = 8'h00;
  logic [1:0] cnt_q = 2'h0;
  // answers while the readback request stands and corrupt is low, shows the inverse otherwise
  always_comb nv_rd_data = (nv_rd_q && !corrupt) ? mem_q : ~mem_q;
  always @(posedge clk) begin
    nv_done <= cnt_q == 2'h1;
    if (nv_wr) mem_q <= nv_wr_data;
    cnt_q <= nv_wr ? 2'h2 : cnt_q - {1'b0, cnt_q != 2'h0};
  end
endmodule : esa_nv_model

// ==== verification/testbench.sv ====
// testbench: drives the aggregator with a memory model, checks the error byte
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rst = 1, nv_wr = 0, uart_wr = 0, bad = 0, nv_done, nv_rd_q, ok, run;
  logic [7:0] lv = 0, wd = 0, ud = 0, rd, eu, ei, e;
  localparam logic [47:0] P = {4{12'h400}};
  logic [47:0] pv = P;
  int n_fail = 0, n_checks = 0;
  initial forever #50 clk = ~clk;
  esa_error_status_aggregator dut (.clk, .rst, .selftest_done(lv[0]), .selftest_fail(lv[1]),
    .fatal_evt(lv[2]), .offset_err(lv[3]), .algo_evt(lv[4]), .output_evt(lv[5]),
    .diag_evt(lv[6]), .input_fail(lv[7]), .probe_val(pv), .probe_min({4{12'h100}}),
    .probe_max({4{12'h800}}), .nv_wr, .nv_wr_data(wd), .nv_done, .nv_rd_data(rd), .uart_wr,
    .uart_wr_data(ud), .err_uart_q(eu), .err_i2c_q(ei), .status_ok_q(ok), .running_q(run),
    .nv_rd_q);
  esa_nv_model mem (.clk, .nv_wr, .nv_rd_q, .corrupt(bad), .nv_wr_data(wd), .nv_done,
    .nv_rd_data(rd));
  task chk(string n, logic [7:0] x, logic [7:0] g);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task rd_byte(logic [7:0] x);
    chk("err_uart", x, eu);
    chk("err_i2c", x, ei);
    chk("status_ok", {7'h00, x == 8'h00}, {7'h00, ok});
  endtask : rd_byte
  task put(logic [7:0] v, logic [47:0] p, logic [7:0] x);
    @(posedge clk) lv <= v;
    pv <= p;
    @(posedge clk) #1 rd_byte(x);
  endtask : put
  task wr_byte(logic [7:0] d, logic [7:0] x);
    @(posedge clk) uart_wr <= 1;
    ud <= d;
    @(posedge clk) uart_wr <= 0;
    #1 rd_byte(x);
  endtask : wr_byte
  task nv_write(logic [7:0] d, logic b, logic [7:0] x);
    @(posedge clk) nv_wr <= 1;
    wd <= d;
    bad <= b;
    @(posedge clk) nv_wr <= 0;
    repeat (5) @(posedge clk);
    #1 rd_byte(x);
  endtask : nv_write
  task wrap_up;
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    put(8'h03, P, 8'h01);
    chk("running", 8'h01, {7'h00, run});
    put(8'h02, P, 8'h01);
    wr_byte(8'h00, 8'h00);
    e = 8'h00;
    for (int k = 2; k < 7; k++) begin
      if (k != 3) e = e | (8'h01 << (k == 2 ? 0 : k - 2));
      if (k != 3) put(8'h01 << k, P, e);
      put(8'h00, P, e);
    end
    nv_write(8'h3C, 1, 8'h5D);
    wr_byte(8'hFF, 8'h5D);
    wr_byte(8'h00, 8'h00);
    nv_write(8'hA5, 0, 8'h00);
    put(8'h00, {12'h900, P[35:0]}, 8'h20);
    put(8'h00, {P[47:12], 12'h0FF}, 8'h20);
    put(8'hC8, P, 8'h32);
    put(8'h00, P, 8'h10);
    @(posedge clk) rst <= 1;
    repeat (2) @(posedge clk);
    #1 rd_byte(8'h00);
    chk("running", 8'h00, {7'h00, run});
    @(posedge clk) rst <= 0;
    put(8'h01, P, 8'h00);
    chk("running", 8'h01, {7'h00, run});
    wrap_up();
  end
endmodule : testbench
